//--- dv/sdp_cmd_pins_tb_top.sv
`timescale 1ns/10ps
module sdp_cmd_pins_tb_top;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, err, termination_enable;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        diffClkPos, diffClkNeg, clockGate, chipSelN, rowStrobeN, columnStrobeN;
   logic        writeStrobeN, terminationEnable, deviceClearN, upperByteMask, lowerByteMask;
   logic        dqOeN, lowerStrobeIn, lowerStrobeOut, lowerStrobeOeN, upperStrobeIn;
   logic        upperStrobeOut, upperStrobeOeN, internalClkRun, outDrvEn, termOn, accValid;
   logic [2:0]  bankSelect, accBank, b;
   logic [13:0] addrLines, accRow, row, mrv[4];
   logic [15:0] dqIn, dqOut, d, mem[8];
   logic [9:0]  accCol, col;
   logic [4:0]  inputBufEn;
   logic [1:0]  m;
   int          fails, numChecks;

   sdp_cmd_pins   dut (.*);
   sdp_ctrl_model ctl (.*);

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Runs a read while watching the data pins beat by beat.
   task automatic burst(input logic [13:0] a, input int len);
      int n;
      int k;
      logic [26:0] ab;
      fork
         ctl.cmd(sdp_pkg::CMD_RD, b, a, 1'b1, termination_enable);
         repeat (30) begin
            @(posedge clk);
            #1;
            if (accValid === 1'b1) begin
               n++;
               ab = {accBank, accRow, accCol};
            end
            if (dqOeN === 1'b0) begin
               chk(dqOut, mem[3'(a[2:0] + k)]);
               chk({lowerStrobeOut, upperStrobeOut, lowerStrobeOeN, upperStrobeOeN}, {~k[0], ~k[0], 2'b00});
               k++;
            end
         end
      join
      chk(n, len);
      chk(k, len);
      chk(ab, {b, row, a[9:0]});
      chk({lowerStrobeOut, upperStrobeOeN}, 2'b01);
      chk({upperStrobeOut, lowerStrobeOeN, dqOeN}, 3'b011);
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d fails=%0d", numChecks, fails);
      if (fails == 0 && numChecks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #200000;
      fails++;
      tally_and_finish();
   end

   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata, termination_enable} = '0;
      mem = '{default: '0};
      void'($urandom(32'he0f958b7));
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge clk);
      apb(0, sdp_pkg::ADDR_STAT, 0);
      chk(rd, 0);
      chk({internalClkRun, outDrvEn, inputBufEn}, 7'h7F);
      apb(0, 8'h1C, 0);
      chk(err, 1);
      apb(1, sdp_pkg::ADDR_CTRL, 1);
      apb(0, sdp_pkg::ADDR_CTRL, 0);
      chk(rd, 1);
      apb(1, sdp_pkg::ADDR_CTRL, 0);
      $display("apb test done");
      for (int i = 0; i < 4; i++) begin
         mrv[i] = 14'($urandom);
         if (i == 0) mrv[i][1:0] = 2'b01;
         if (i == 1) mrv[i][2] = 1'b1;
         ctl.cmd(sdp_pkg::CMD_MRS, 3'(i), mrv[i], 1'b1, termination_enable);
         apb(0, 8'(sdp_pkg::ADDR_MR0 + 4 * i), 0);
         chk(rd, 32'(mrv[i]));
      end
      ctl.cmd(sdp_pkg::CMD_MRS, 3'd4, ~mrv[0], 1'b1, termination_enable);
      ctl.cmd(4'h8, 3'd0, ~mrv[0], 1'b1, termination_enable);
      apb(0, sdp_pkg::ADDR_MR0, 0);
      chk(rd, 32'(mrv[0]));
      termination_enable = 1'b1;
      ctl.cmd(4'h7, 3'd0, 14'h0, 1'b1, termination_enable);
      chk(termOn, 1);
      apb(1, sdp_pkg::ADDR_CTRL, 1);
      repeat (2) @(posedge clk);
      #1;
      chk(termOn, 0);
      apb(1, sdp_pkg::ADDR_CTRL, 0);
      // Clearing every termination field in both mode registers must mute termination.
      ctl.cmd(sdp_pkg::CMD_MRS, 3'd1, mrv[1] & 14'h3DBB, 1'b1, termination_enable);
      ctl.cmd(sdp_pkg::CMD_MRS, 3'd2, mrv[2] & 14'h39FF, 1'b1, termination_enable);
      chk(termOn, 0);
      ctl.cmd(sdp_pkg::CMD_MRS, 3'd1, mrv[1], 1'b1, termination_enable);
      ctl.cmd(sdp_pkg::CMD_MRS, 3'd2, mrv[2], 1'b1, termination_enable);
      chk(termOn, 1);
      $display("mode test done");
      b = 3'($urandom);
      row = 14'($urandom);
      col = 10'($urandom);
      ctl.cmd(sdp_pkg::CMD_ACT, b, row, 1'b1, termination_enable);
      ctl.cmd(4'hB, ~b, row, 1'b1, termination_enable);
      apb(0, sdp_pkg::ADDR_STAT, 0);
      chk(rd[15:0], {8'(1 << b), 8'h04});
      ctl.cmd(sdp_pkg::CMD_WR, b, {4'b0100, col}, 1'b1, termination_enable);
      for (int i = 0; i < 8; i++) begin
         d = 16'($urandom);
         m = 2'($urandom);
         ctl.beat(d, m);
         if (!m[0]) mem[3'(col[2:0] + i)][7:0] = d[7:0];
         if (!m[1]) mem[3'(col[2:0] + i)][15:8] = d[15:8];
      end
      for (int i = 0; i < 40 && accValid !== 1'b0; i++) @(posedge clk);
      col = 10'($urandom);
      burst({4'b0001, col}, 4);
      apb(0, sdp_pkg::ADDR_STAT, 0);
      chk(rd[15:8], 0);
      $display("data test done");
      ctl.cmd(sdp_pkg::CMD_ACT, b, row, 1'b1, termination_enable);
      ctl.cmd(4'h7, 3'd0, 14'h0, 1'b0, termination_enable);
      apb(0, sdp_pkg::ADDR_STAT, 0);
      chk(rd[1:0], 2);
      chk({internalClkRun, outDrvEn, inputBufEn}, 7'h07);
      ctl.cmd(4'h7, 3'd0, 14'h0, 1'b1, termination_enable);
      ctl.cmd(sdp_pkg::CMD_ACT, ~b, row, 1'b1, termination_enable);
      ctl.cmd(sdp_pkg::CMD_PRE, b, 14'h0, 1'b1, termination_enable);
      apb(0, sdp_pkg::ADDR_STAT, 0);
      chk(rd[15:0], {8'(1 << (~b)), 8'h04});
      ctl.cmd(sdp_pkg::CMD_PRE, b, 14'h0400, 1'b1, termination_enable);
      ctl.cmd(4'h7, 3'd0, 14'h0, 1'b0, termination_enable);
      apb(0, sdp_pkg::ADDR_STAT, 0);
      chk(rd[15:0], 16'h0005);
      ctl.cmd(4'h7, 3'd0, 14'h0, 1'b1, termination_enable);
      ctl.cmd(sdp_pkg::CMD_REF, 3'd0, 14'h0, 1'b0, termination_enable);
      chk({termOn, inputBufEn}, 6'h04);
      ctl.gate_up();
      repeat (6) @(posedge clk);
      apb(0, sdp_pkg::ADDR_STAT, 0);
      chk(rd[2:0], 3'h4);
      $display("power test done");
      ctl.clear();
      repeat (6) @(posedge clk);
      apb(0, sdp_pkg::ADDR_MR1, 0);
      chk(rd, 0);
      apb(0, sdp_pkg::ADDR_STAT, 0);
      chk(rd, 0);
      $display("clear test done");
      tally_and_finish();
   end
endmodule // sdp_cmd_pins_tb_top

//--- dv/sdp_ctrl_model.sv
`timescale 1ns/10ps
module sdp_ctrl_model (
   // Clock
   input wire logic    clk,
   // Command, address and data pins
   output logic        diffClkPos,
   output logic        diffClkNeg,
   output logic        clockGate,
   output logic        chipSelN,
   output logic        rowStrobeN,
   output logic        columnStrobeN,
   output logic        writeStrobeN,
   output logic [2:0]  bankSelect,
   output logic [13:0] addrLines,
   output logic        terminationEnable,
   output logic        deviceClearN,
   output logic        upperByteMask,
   output logic        lowerByteMask,
   output logic [15:0] dqIn,
   output logic        lowerStrobeIn,
   output logic        upperStrobeIn
);
   initial begin
      {diffClkPos, diffClkNeg, clockGate, chipSelN, deviceClearN} = 5'b01111;
      {rowStrobeN, columnStrobeN, writeStrobeN} = 3'b111;
      {bankSelect, addrLines, terminationEnable, upperByteMask, lowerByteMask} = '0;
      {dqIn, lowerStrobeIn, upperStrobeIn} = '0;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
                      input logic g, input logic t);
      @(posedge clk);
      {chipSelN, rowStrobeN, columnStrobeN, writeStrobeN} <= c;
      bankSelect <= b;
      addrLines <= a;
      clockGate <= g;
      terminationEnable <= t;
      cyc(4);
      diffClkPos <= 1'b1;
      diffClkNeg <= 1'b0;
      cyc(4);
      diffClkPos <= 1'b0;
      diffClkNeg <= 1'b1;
      // Deselected lines carry junk so nothing can lean on stale values.
      chipSelN <= 1'b1;
      bankSelect <= ~b;
      addrLines <= ~a;
      cyc(4);
   endtask

   task automatic beat(input logic [15:0] d, input logic [1:0] m);
      @(posedge clk);
      dqIn <= d;
      {upperByteMask, lowerByteMask} <= m;
      cyc(4);
      lowerStrobeIn <= ~lowerStrobeIn;
      upperStrobeIn <= ~upperStrobeIn;
      cyc(4);
      dqIn <= ~d;
      {upperByteMask, lowerByteMask} <= ~m;
   endtask

   task automatic clear();
      @(posedge clk);
      deviceClearN <= 1'b0;
      cyc(2);
      deviceClearN <= 1'b1;
   endtask

   task automatic gate_up();
      @(posedge clk);
      clockGate <= 1'b1;
   endtask
endmodule // sdp_ctrl_model

//--- hdl/sdp_byte_lane.sv
`timescale 1ns/10ps
module sdp_byte_lane (
   // Clock and reset
   input wire logic clk,
   input wire logic rstN,
   // Lane pins and captured beat
   sdp_lane_if.lane ln
);

   typedef struct packed {
      logic [9:0] s1;
      logic [9:0] s2;
      logic       prev;
      logic       beat;
      logic [7:0] data;
      logic       keep;
   } sdp_lane_st_t;

   sdp_lane_st_t q;
   sdp_lane_st_t d;

   // ************************************************************
   // Beat capture.
   // ************************************************************
   always_comb begin
      d      = q;
      d.s1   = {ln.strobe, ln.mask, ln.dq};
      d.s2   = q.s1;
      d.prev = q.s2[9];
      d.beat = q.s2[9] ^ q.prev;
      d.data = q.s2[7:0];
      d.keep = ~q.s2[8];
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign ln.beat = q.beat;
   assign ln.data = q.data;
   assign ln.keep = q.keep;

   property p_mask_drop;
      @(posedge clk) disable iff (!rstN)
         ((q.s2[9] ^ q.prev) && q.s2[8]) |=> (ln.beat && !ln.keep);
   endproperty
   a_mask_drop: assert property (p_mask_drop) else $error("masked byte kept");

endmodule // sdp_byte_lane

//--- hdl/sdp_cmd_pins.sv
`timescale 1ns/10ps
module sdp_cmd_pins (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Command and address pins
   input  wire logic        diffClkPos,
   input  wire logic        diffClkNeg,
   input  wire logic        clockGate,
   input  wire logic        chipSelN,
   input  wire logic        rowStrobeN,
   input  wire logic        columnStrobeN,
   input  wire logic        writeStrobeN,
   input  wire logic [2:0]  bankSelect,
   input  wire logic [13:0] addrLines,
   input  wire logic        terminationEnable,
   input  wire logic        deviceClearN,
   // Data pins
   input  wire logic        upperByteMask,
   input  wire logic        lowerByteMask,
   input  wire logic [15:0] dqIn,
   output logic      [15:0] dqOut,
   output logic             dqOeN,
   input  wire logic        lowerStrobeIn,
   output logic             lowerStrobeOut,
   output logic             lowerStrobeOeN,
   input  wire logic        upperStrobeIn,
   output logic             upperStrobeOut,
   output logic             upperStrobeOeN,
   // Internal state views
   output logic             internalClkRun,
   output logic             outDrvEn,
   output logic      [4:0]  inputBufEn,
   output logic             termOn,
   output logic             accValid,
   output logic      [2:0]  accBank,
   output logic      [13:0] accRow,
   output logic      [9:0]  accCol
);

   typedef struct packed {
      logic        pos;
      logic        neg;
      logic        cke;
      logic [3:0]  cmd;
      logic [2:0]  ba;
      logic [13:0] addr;
      logic        termination_enable;
   } sdp_pins_t;

   typedef struct packed {
      sdp_pins_t        p1;
      sdp_pins_t        p2;
      logic             clkPrev;
      sdp_pkg::sdp_pwr_t pwr;
      logic [7:0]       open;
      logic [7:0][13:0] row;
      logic [3:0][13:0] mr;
      logic             odtCap;
      logic             termOff;
      logic [31:0]      cmdCnt;
      logic             rdAct;
      logic             wrAct;
      logic             ap;
      logic [2:0]       bank;
      logic [9:0]       col;
      logic [3:0]       left;
      logic [2:0]       idx;
      logic [7:0][15:0] buffer;
      logic [15:0]      dqOut;
      logic             strobe;
      logic             drive;
      logic [31:0]      prdata;
   } sdp_top_st_t;

   sdp_top_st_t q;
   sdp_top_st_t d;

   logic [1:0]  rstSync;
   logic        rawRstN;
   logic        rstN;
   logic        crossEv;
   logic        cmdLive;
   logic        isAct;
   logic        isRd;
   logic        isWr;
   logic        isPre;
   logic        isMrs;
   logic        isRef;
   logic        anyOpen;
   logic        termDis;
   logic        otfOk;
   logic        chop;
   logic        beatNow;
   logic        hit;
   logic [31:0] rdVal;

   sdp_lane_if lowIf ();
   sdp_lane_if upIf ();

   // ************************************************************
   // Reset.
   // ************************************************************
   // clear is async reset
   assign rawRstN = rst_b & deviceClearN;

   always_ff @(posedge clk or negedge rawRstN) begin
      if (!rawRstN) begin
         rstSync <= 2'b00;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end

   assign rstN = rstSync[1];

   // ************************************************************
   // Byte lanes.
   // ************************************************************
   assign lowIf.strobe = lowerStrobeIn;
   assign lowIf.dq     = dqIn[7:0];
   assign lowIf.mask   = lowerByteMask;
   assign upIf.strobe  = upperStrobeIn;
   assign upIf.dq      = dqIn[15:8];
   assign upIf.mask    = upperByteMask;

   sdp_byte_lane uLow (
      .clk  (clk),
      .rstN (rstN),
      .ln   (lowIf.lane)
   );

   sdp_byte_lane uUp (
      .clk  (clk),
      .rstN (rstN),
      .ln   (upIf.lane)
   );

   // ************************************************************
   // Decode.
   // ************************************************************
   // positive leg rising
   assign crossEv = q.p2.pos & ~q.clkPrev & ~q.p2.neg;
   assign cmdLive = crossEv & (q.pwr == sdp_pkg::PWR_ON) & q.p2.cke & ~q.p2.cmd[3];
   assign isAct   = cmdLive & (q.p2.cmd == sdp_pkg::CMD_ACT);
   assign isRd    = cmdLive & (q.p2.cmd == sdp_pkg::CMD_RD);
   assign isWr    = cmdLive & (q.p2.cmd == sdp_pkg::CMD_WR);
   assign isPre   = cmdLive & (q.p2.cmd == sdp_pkg::CMD_PRE);
   assign isMrs   = cmdLive & (q.p2.cmd == sdp_pkg::CMD_MRS);
   assign isRef   = cmdLive & (q.p2.cmd == sdp_pkg::CMD_REF);
   assign anyOpen = |q.open;
   assign termDis = ~(q.mr[1][sdp_pkg::MR1_RTT_A] | q.mr[1][sdp_pkg::MR1_RTT_B]
                      | q.mr[1][sdp_pkg::MR1_RTT_C])
                    & ~(q.mr[2][sdp_pkg::MR2_RTTW_A] | q.mr[2][sdp_pkg::MR2_RTTW_B]);
   assign otfOk   = (q.mr[0][1:0] == sdp_pkg::BL_OTF);
   assign chop    = otfOk ? ~q.p2.addr[sdp_pkg::BC_BIT] : (q.mr[0][1:0] == sdp_pkg::BL_CHOP);
   assign beatNow = q.rdAct | (q.wrAct & lowIf.beat);
   assign hit     = (paddr <= sdp_pkg::ADDR_CNT) && (paddr[1:0] == 2'b00);

   always_comb begin
      rdVal = '0;
      case (paddr)
         sdp_pkg::ADDR_CTRL: begin
            rdVal[sdp_pkg::CTRL_TERM_OFF] = q.termOff;
         end
         sdp_pkg::ADDR_STAT: begin
            rdVal[sdp_pkg::STAT_PWR_LSB +: 2]  = q.pwr;
            rdVal[sdp_pkg::STAT_TERM]          = termOn;
            rdVal[sdp_pkg::STAT_RD]            = q.rdAct;
            rdVal[sdp_pkg::STAT_WR]            = q.wrAct;
            rdVal[sdp_pkg::STAT_OPEN_LSB +: 8] = q.open;
         end
         sdp_pkg::ADDR_MR0: rdVal[13:0] = q.mr[0];
         sdp_pkg::ADDR_MR1: rdVal[13:0] = q.mr[1];
         sdp_pkg::ADDR_MR2: rdVal[13:0] = q.mr[2];
         sdp_pkg::ADDR_MR3: rdVal[13:0] = q.mr[3];
         sdp_pkg::ADDR_CNT: rdVal       = q.cmdCnt;
         default:           rdVal       = '0;
      endcase
   end

   // ************************************************************
   // Next state.
   // ************************************************************
   always_comb begin
      d         = q;
      d.p1      = {diffClkPos, diffClkNeg, clockGate, chipSelN, rowStrobeN, columnStrobeN,
                   writeStrobeN, bankSelect, addrLines, terminationEnable};
      d.p2      = q.p1;
      d.clkPrev = q.p2.pos;
      d.drive   = q.rdAct;

      case (q.pwr)
         sdp_pkg::PWR_ON: begin
            if (crossEv && !q.p2.cke) begin
               if (anyOpen) begin
                  d.pwr = sdp_pkg::PWR_ACT_DOWN;
               end else if (q.p2.cmd == sdp_pkg::CMD_REF) begin
                  d.pwr = sdp_pkg::PWR_SELF_REF;
               end else begin
                  d.pwr = sdp_pkg::PWR_PRE_DOWN;
               end
            end
         end
         sdp_pkg::PWR_PRE_DOWN, sdp_pkg::PWR_ACT_DOWN: begin
            if (crossEv && q.p2.cke) begin
               d.pwr = sdp_pkg::PWR_ON;
            end
         end
         sdp_pkg::PWR_SELF_REF: begin
            if (q.p2.cke) begin
               d.pwr = sdp_pkg::PWR_ON;
            end
         end
         default: d.pwr = sdp_pkg::PWR_ON;
      endcase

      if (crossEv && (q.pwr != sdp_pkg::PWR_SELF_REF)) begin
         d.odtCap = q.p2.termination_enable;
      end

      if (isAct | isRd | isWr | isPre | isMrs | isRef) begin
         d.cmdCnt = q.cmdCnt + 32'h0000_0001;
      end

      d.strobe = q.rdAct ? ~q.strobe : 1'b0;
      if (q.rdAct) begin
         d.dqOut = q.buffer[q.idx];
      end
      if (q.wrAct && lowIf.beat && lowIf.keep) begin
         d.buffer[q.idx][7:0] = lowIf.data;
      end
      if (q.wrAct && upIf.beat && upIf.keep) begin
         d.buffer[q.idx][15:8] = upIf.data;
      end
      if (beatNow) begin
         d.idx  = q.idx + 3'h1;
         d.left = q.left - 4'h1;
         if (q.left == 4'h1) begin
            d.rdAct = 1'b0;
            d.wrAct = 1'b0;
            if (q.ap) begin
               d.open[q.bank] = 1'b0;
            end
         end
      end

      if (isAct) begin
         d.open[q.p2.ba] = 1'b1;
         d.row[q.p2.ba]  = q.p2.addr;
      end
      if (isPre) begin
         if (q.p2.addr[sdp_pkg::AP_BIT]) begin
            d.open = '0;
         end else begin
            d.open[q.p2.ba] = 1'b0;
         end
      end
      if (isMrs && !q.p2.ba[2]) begin
         d.mr[q.p2.ba[1:0]] = q.p2.addr;
      end
      if ((isRd || isWr) && q.open[q.p2.ba] && !q.rdAct && !q.wrAct) begin
         d.rdAct = isRd;
         d.wrAct = isWr;
         d.bank  = q.p2.ba;
         d.col   = q.p2.addr[9:0];
         d.ap    = q.p2.addr[sdp_pkg::AP_BIT];
         d.idx   = q.p2.addr[2:0];
         d.left  = chop ? sdp_pkg::BEATS_CHOP : sdp_pkg::BEATS_FULL;
      end

      if (psel && !penable) begin
         d.prdata = rdVal;
      end
      if (psel && penable && pwrite && (paddr == sdp_pkg::ADDR_CTRL)) begin
         d.termOff = pwdata[sdp_pkg::CTRL_TERM_OFF];
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // Outputs.
   // ************************************************************
   // gate runs clocks and drivers
   assign internalClkRun = (q.pwr == sdp_pkg::PWR_ON);
   assign outDrvEn       = (q.pwr == sdp_pkg::PWR_ON);

   always_comb begin
      case (q.pwr)
         sdp_pkg::PWR_ON:       inputBufEn = sdp_pkg::BUF_ALL;
         sdp_pkg::PWR_SELF_REF: inputBufEn = sdp_pkg::BUF_SR;
         default:               inputBufEn = sdp_pkg::BUF_PD;
      endcase
   end

   assign termOn = q.odtCap & (q.pwr != sdp_pkg::PWR_SELF_REF) & ~termDis & ~q.termOff;

   assign dqOut          = q.dqOut;
   assign dqOeN          = ~q.drive;
   assign lowerStrobeOut = q.strobe;
   assign upperStrobeOut = q.strobe;
   assign lowerStrobeOeN = ~q.drive;
   assign upperStrobeOeN = ~q.drive;
   assign accValid       = q.rdAct | q.wrAct;
   assign accBank        = q.bank;
   assign accRow         = q.row[q.bank];
   assign accCol         = q.col;
   assign prdata         = q.prdata;
   assign pready         = 1'b1;
   assign pslverr        = psel & penable & ~hit;

   // ************************************************************
   // Checks.
   // ************************************************************
   property p_capture;
      @(posedge clk) disable iff (!rstN)
         (q.cmdCnt != $past(q.cmdCnt)) |-> $past(crossEv);
   endproperty
   a_capture: assert property (p_capture) else $error("command taken off crossing");

   property p_gate_off;
      @(posedge clk) disable iff (!rstN)
         (crossEv && !q.p2.cke && q.pwr == sdp_pkg::PWR_ON) |=> !internalClkRun && !outDrvEn;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("clocks still run with gate low");

   property p_act_down;
      @(posedge clk) disable iff (!rstN)
         (crossEv && !q.p2.cke && q.pwr == sdp_pkg::PWR_ON && anyOpen)
            |=> q.pwr == sdp_pkg::PWR_ACT_DOWN;
   endproperty
   a_act_down: assert property (p_act_down) else $error("wrong power-down mode");

   property p_sr_exit;
      @(posedge clk) disable iff (!rstN)
         (q.pwr == sdp_pkg::PWR_SELF_REF && q.p2.cke && !crossEv) |=> q.pwr == sdp_pkg::PWR_ON;
   endproperty
   a_sr_exit: assert property (p_sr_exit) else $error("self-refresh exit missed");

   property p_pd_bufs;
      @(posedge clk) disable iff (!rstN)
         (q.pwr == sdp_pkg::PWR_PRE_DOWN || q.pwr == sdp_pkg::PWR_ACT_DOWN)
            |-> inputBufEn == sdp_pkg::BUF_PD && $stable(q.cmdCnt);
   endproperty
   a_pd_bufs: assert property (p_pd_bufs) else $error("power-down buffers wrong");

   property p_sr_term;
      @(posedge clk) disable iff (!rstN)
         (q.pwr == sdp_pkg::PWR_SELF_REF) |-> !termOn && inputBufEn == sdp_pkg::BUF_SR;
   endproperty
   a_sr_term: assert property (p_sr_term) else $error("self-refresh inputs active");

   property p_cs_mask;
      @(posedge clk) disable iff (!rstN)
         (crossEv && q.p2.cmd[3]) |=> $stable(q.cmdCnt) && $stable(q.open);
   endproperty
   a_cs_mask: assert property (p_cs_mask) else $error("deselected command acted");

   property p_activate;
      @(posedge clk) disable iff (!rstN)
         isAct |=> q.open[$past(q.p2.ba)] && q.row[$past(q.p2.ba)] == $past(q.p2.addr);
   endproperty
   a_activate: assert property (p_activate) else $error("activate not recorded");

   property p_pre_all;
      @(posedge clk) disable iff (!rstN)
         (isPre && q.p2.addr[sdp_pkg::AP_BIT] && !isAct) |=> q.open == 8'h00;
   endproperty
   a_pre_all: assert property (p_pre_all) else $error("precharge all left bank open");

   property p_chop_len;
      @(posedge clk) disable iff (!rstN)
         (isRd && !q.rdAct && !q.wrAct && q.open[q.p2.ba] && otfOk && !q.p2.addr[sdp_pkg::BC_BIT])
            |=> q.rdAct ##1 q.rdAct [*3] ##1 !q.rdAct;
   endproperty
   a_chop_len: assert property (p_chop_len) else $error("chopped read not four beats");

endmodule // sdp_cmd_pins

//--- hdl/sdp_lane_if.sv
`timescale 1ns/10ps
interface sdp_lane_if;
   logic       strobe;
   logic [7:0] dq;
   logic       mask;
   logic       beat;
   logic [7:0] data;
   logic       keep;
   modport lane (input strobe, dq, mask, output beat, data, keep);
   modport user (output strobe, dq, mask, input beat, data, keep);
endinterface

//--- hdl/sdp_pkg.sv
// Operation
// - Capture inputs where clock legs cross.
// - Clock gate high runs internal logic.
// - Gate low enters matching power-down mode.
// - Self-refresh exit seen without input clock.
// - Power-down keeps clock, termination, gate buffers.
// - Self-refresh keeps only clock gate buffer.
// - Chip select high masks the command.
// - Termination enable switches on data termination.
// - Termination ignored in self-refresh or disabled.
// - Command decoded from four strobes together.
// - Masked write bytes are not stored.
// - Byte masks sampled on both strobe edges.
// - Bank select picks bank or mode register.
// - Row from address, column from low bits.
// - Mode register opcode from address lines.
// - Auto-precharge bit closes bank after access.
// - Precharge bit selects one or all banks.
// - Burst chop bit low chops burst.
// - Device clear low resets asynchronously.
// - Reset may destroy stored data.
// - Bursts are eight beats, four chopped.
// - On-the-fly chop only when mode allows.
// - Read strobe edge-aligned with read data.

package sdp_pkg;

   // ************************************************************
   // Register map.
   // ************************************************************
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STAT   = 8'h04;
   localparam logic [7:0] ADDR_MR0    = 8'h08;
   localparam logic [7:0] ADDR_MR1    = 8'h0C;
   localparam logic [7:0] ADDR_MR2    = 8'h10;
   localparam logic [7:0] ADDR_MR3    = 8'h14;
   localparam logic [7:0] ADDR_CNT    = 8'h18;
   localparam int         CTRL_TERM_OFF = 0;
   localparam int         STAT_PWR_LSB  = 0;
   localparam int         STAT_TERM     = 2;
   localparam int         STAT_RD       = 3;
   localparam int         STAT_WR       = 4;
   localparam int         STAT_OPEN_LSB = 8;

   // ************************************************************
   // Command codes, chip select first, then row, column, write.
   // ************************************************************
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR  = 4'h4;
   localparam logic [3:0] CMD_RD  = 4'h5;

   // ************************************************************
   // Address and mode register fields.
   // ************************************************************
   localparam int         AP_BIT     = 10;
   localparam int         BC_BIT     = 12;
   localparam int         MR1_RTT_A  = 2;
   localparam int         MR1_RTT_B  = 6;
   localparam int         MR1_RTT_C  = 9;
   localparam int         MR2_RTTW_A = 9;
   localparam int         MR2_RTTW_B = 10;
   localparam logic [1:0] BL_OTF     = 2'h1;
   localparam logic [1:0] BL_CHOP    = 2'h2;
   localparam logic [3:0] BEATS_FULL = 4'h8;
   localparam logic [3:0] BEATS_CHOP = 4'h4;

   // ************************************************************
   // Input buffer groups: clock legs, termination, gate, cmd, data.
   // ************************************************************
   localparam logic [4:0] BUF_ALL = 5'h1F;
   localparam logic [4:0] BUF_PD  = 5'h07;
   localparam logic [4:0] BUF_SR  = 5'h04;

   typedef enum logic [1:0] {
      PWR_ON,
      PWR_PRE_DOWN,
      PWR_ACT_DOWN,
      PWR_SELF_REF
   } sdp_pwr_t;

endpackage
